// ---- src/mwsr_pkg.sv ----
// Shared constants for the masked-write status register bank
package mwsr_pkg;

  localparam int unsigned MWSR_AW = 20;
  localparam int unsigned MWSR_DW = 32;

  // Memory map
  localparam logic [19:0] MWSR_SRAM_LO   = 20'h00000;
  localparam logic [19:0] MWSR_SRAM_HI   = 20'h01fff;
  localparam logic [19:0] MWSR_PERIPH_LO = 20'h40000;
  localparam logic [19:0] MWSR_PERIPH_HI = 20'h4ffff;
  localparam logic [19:0] MWSR_BOOT_LO   = 20'h80000;
  localparam logic [19:0] MWSR_BOOT_HI   = 20'h81fff;
  localparam logic [19:0] MWSR_FLASH_LO  = 20'h90000;
  localparam logic [19:0] MWSR_FLASH_HI  = 20'haffff;

  // Per-module block bases, each block 256 bytes
  localparam logic [19:0] MWSR_SYSCTL_BASE  = 20'h40100;
  localparam logic [19:0] MWSR_PMU_BASE     = 20'h40400;
  localparam logic [19:0] MWSR_DISPLAY_BASE = 20'h41b00;
  localparam logic [19:0] MWSR_BLOCK_MASK   = 20'hfff00;
  localparam logic [19:0] MWSR_RESET_VECTOR = 20'h80000;

  // Register addresses
  localparam logic [19:0] MWSR_PORT1_IRQ_ADDR = 20'h40010;
  localparam logic [19:0] MWSR_STATUS_ADDR    = 20'h40104;

  // Masked-write layout
  localparam int unsigned MWSR_HI_MASK_POS = 24;
  localparam int unsigned MWSR_HI_DATA_POS = 16;
  localparam int unsigned MWSR_LO_MASK_POS = 8;
  localparam int unsigned MWSR_LO_DATA_POS = 0;

  // Status register fields
  localparam int unsigned MWSR_OVERVOLT_BIT  = 7;
  localparam int unsigned MWSR_UNDERVOLT_BIT = 6;
  localparam int unsigned MWSR_CORE_RST_BIT  = 5;
  localparam int unsigned MWSR_IDLE_SEL_BIT  = 4;
  localparam int unsigned MWSR_LP_ENTER_BIT  = 3;
  localparam int unsigned MWSR_TIMER_RST_BIT = 2;
  localparam int unsigned MWSR_EXT_RST_BIT   = 1;
  localparam int unsigned MWSR_BROWNOUT_BIT  = 0;

  // Fixed configuration bytes of the status register upper half
  localparam logic [7:0] MWSR_CFG_HI = 8'h0f;
  localparam logic [7:0] MWSR_CFG_LO = 8'h1a;

  // Reset values
  localparam logic [7:0] MWSR_PORT1_EN_RST   = 8'h00;
  localparam logic [7:0] MWSR_PORT1_FLAG_RST = 8'h00;
  localparam logic       MWSR_IDLE_SEL_RST   = 1'b0;

  localparam int unsigned MWSR_SRAM_WORDS = 2048;

endpackage

// ---- src/mwsr_top.sv ----
// Register bank with masked writes, system status register and bus decode
`timescale 1ns/1ps
`default_nettype none

module mwsr_top
  import mwsr_pkg::*;
(
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // Peripheral bus slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [19:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Region selects for the rest of the system
  output logic             SEL_SRAM,
  output logic             SEL_PERIPH,
  output logic             SEL_BOOT_ROM,
  output logic             SEL_FLASH,
  output logic             SEL_SYSCTL,
  output logic             SEL_PMU,
  output logic             SEL_DISPLAY,
  output logic      [19:0] FETCH_START_ADDR,
  // Supply and reset-cause events
  input  wire logic        CORE_SUPPLY_HIGH,
  input  wire logic        CORE_SUPPLY_LOW,
  input  wire logic        CORE_RESET_EVT,
  input  wire logic        LOW_POWER_EVT,
  input  wire logic        CIRCUIT_RESET_EVT,
  input  wire logic        TIMER_EXPIRY_EVT,
  input  wire logic        EXT_RESET_EVT,
  input  wire logic        PIN_RESET_EVT,
  input  wire logic        PROG_RESET_EVT,
  input  wire logic        BROWNOUT_EVT,
  input  wire logic        SUPPLY_ABOVE_1V8,
  // Port 1 pin interrupt events
  input  wire logic [7:0]  PORT1_PIN_EVT,
  // Block outputs
  output logic             LOW_POWER_IDLE_SEL,
  output logic             CPU_CLK_HOLD,
  output logic      [7:0]  PORT1_PIN_IRQ_ENABLE,
  output logic      [7:0]  PORT1_PIN_IRQ_FLAG
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [31:0] rdata;
    logic        slverr;
    logic [7:0]  p1_en;
    logic [7:0]  p1_flag;
    logic        idle_sel;
    logic        core_reset_flag;
    logic        low_power_entered_flag;
    logic        timer_expiry_reset_flag;
    logic        ext_reset_flag;
    logic        brownout_reset_flag;
    logic        above_1v8_d;
  } mwsr_state_s;

  mwsr_state_s cur;
  mwsr_state_s next_cur;

  logic [31:0] sram [MWSR_SRAM_WORDS];

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Merge one guarded byte: a bit takes new data only where its mask bit is set
  function automatic logic [7:0] masked_byte(input logic [7:0] old, input logic [7:0] msk,
                                             input logic [7:0] dat);
    masked_byte = (msk & dat) | (~msk & old);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  logic setup_ph;
  logic access_wr;
  logic hit_p1;
  logic hit_stat;
  logic hit_sram;
  logic known;
  logic [10:0] sram_idx;

  always_comb begin
    SEL_SRAM     = in_range(PADDR, MWSR_SRAM_LO, MWSR_SRAM_HI);
    SEL_PERIPH   = in_range(PADDR, MWSR_PERIPH_LO, MWSR_PERIPH_HI);
    SEL_BOOT_ROM = in_range(PADDR, MWSR_BOOT_LO, MWSR_BOOT_HI);
    SEL_FLASH    = in_range(PADDR, MWSR_FLASH_LO, MWSR_FLASH_HI);
    SEL_SYSCTL   = (PADDR & MWSR_BLOCK_MASK) == MWSR_SYSCTL_BASE;
    SEL_PMU      = (PADDR & MWSR_BLOCK_MASK) == MWSR_PMU_BASE;
    SEL_DISPLAY  = (PADDR & MWSR_BLOCK_MASK) == MWSR_DISPLAY_BASE;
  end

  assign FETCH_START_ADDR = MWSR_RESET_VECTOR;
  assign setup_ph  = PSEL && !PENABLE;
  assign access_wr = PSEL && PENABLE && PWRITE;
  assign hit_p1    = (PADDR == MWSR_PORT1_IRQ_ADDR);
  assign hit_stat  = (PADDR == MWSR_STATUS_ADDR);
  assign hit_sram  = SEL_SRAM;
  assign sram_idx  = PADDR[12:2];
  // Other peripheral and memory regions answer without error; their data lives elsewhere
  assign known     = SEL_SRAM || SEL_PERIPH || SEL_BOOT_ROM || SEL_FLASH;

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [31:0] stat_word;
  logic [31:0] p1_word;

  always_comb begin
    next_cur = cur;

    // Mask positions are never stored, so they read as zero
    p1_word   = {8'h00, cur.p1_en, 8'h00, cur.p1_flag};
    stat_word = {MWSR_CFG_HI, MWSR_CFG_LO, 8'h00,
                 CORE_SUPPLY_HIGH,
                 CORE_SUPPLY_LOW,
                 cur.core_reset_flag,
                 cur.idle_sel,
                 cur.low_power_entered_flag,
                 cur.timer_expiry_reset_flag,
                 cur.ext_reset_flag,
                 cur.brownout_reset_flag};

    // Read data is captured in the setup phase so the access phase needs no wait
    if (setup_ph && !PWRITE) begin
      if (hit_p1) begin
        next_cur.rdata = p1_word;
      end else if (hit_stat) begin
        next_cur.rdata = stat_word;
      end else if (hit_sram) begin
        next_cur.rdata = sram[sram_idx];
      end else begin
        next_cur.rdata = 32'h0000_0000;
      end
    end
    if (setup_ph) begin
      next_cur.slverr = !known;
    end

    // Masked register writes
    if (access_wr && hit_p1) begin
      next_cur.p1_en   = masked_byte(cur.p1_en, PWDATA[MWSR_HI_MASK_POS +: 8],
                                     PWDATA[MWSR_HI_DATA_POS +: 8]);
      next_cur.p1_flag = masked_byte(cur.p1_flag, PWDATA[MWSR_LO_MASK_POS +: 8],
                                     PWDATA[MWSR_LO_DATA_POS +: 8]);
    end
    if (access_wr && hit_stat && PWDATA[MWSR_LO_MASK_POS + MWSR_IDLE_SEL_BIT]) begin
      next_cur.idle_sel = PWDATA[MWSR_IDLE_SEL_BIT];
    end

    // Pin events win over a clearing write in the same cycle
    next_cur.p1_flag = next_cur.p1_flag | PORT1_PIN_EVT;

    // Reset-cause flags: clear sources first, set sources last so a set wins
    if (cur.above_1v8_d == 1'b0 && SUPPLY_ABOVE_1V8) begin
      next_cur.brownout_reset_flag = 1'b0;
    end
    if (BROWNOUT_EVT || CIRCUIT_RESET_EVT) begin
      next_cur.low_power_entered_flag = 1'b0;
    end
    if (BROWNOUT_EVT || EXT_RESET_EVT) begin
      next_cur.timer_expiry_reset_flag = 1'b0;
    end
    if (BROWNOUT_EVT) begin
      next_cur.ext_reset_flag = 1'b0;
    end
    if (CORE_RESET_EVT) begin
      next_cur.core_reset_flag = 1'b1;
    end
    if (LOW_POWER_EVT) begin
      next_cur.low_power_entered_flag = 1'b1;
    end
    if (TIMER_EXPIRY_EVT) begin
      next_cur.timer_expiry_reset_flag = 1'b1;
    end
    if (PIN_RESET_EVT || PROG_RESET_EVT) begin
      next_cur.ext_reset_flag = 1'b1;
    end
    if (BROWNOUT_EVT) begin
      next_cur.brownout_reset_flag = 1'b1;
    end
    next_cur.above_1v8_d = SUPPLY_ABOVE_1V8;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cur                         <= '0;
      cur.p1_en                   <= MWSR_PORT1_EN_RST;
      cur.p1_flag                 <= MWSR_PORT1_FLAG_RST;
      cur.idle_sel                <= MWSR_IDLE_SEL_RST;
    end else begin
      cur <= next_cur;
    end
  end

  // SRAM array kept outside the state struct: it has no reset and byte lanes
  always_ff @(posedge REF_CLK) begin
    if (access_wr && hit_sram) begin
      for (int b = 0; b < 4; b++) begin
        if (PSTRB[b]) begin
          sram[sram_idx][8*b +: 8] <= PWDATA[8*b +: 8];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign PRDATA               = cur.rdata;
  assign PREADY               = 1'b1;
  assign PSLVERR              = PSEL && PENABLE && cur.slverr;
  assign LOW_POWER_IDLE_SEL   = cur.idle_sel;
  assign CPU_CLK_HOLD         = CORE_SUPPLY_LOW;
  assign PORT1_PIN_IRQ_ENABLE = cur.p1_en;
  assign PORT1_PIN_IRQ_FLAG   = cur.p1_flag;

endmodule

`default_nettype wire

// ---- dv/mwsr_props.sv ----
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module mwsr_props
  import mwsr_pkg::*;
(
  // Clock, reset and bus
  input wire logic        REF_CLK,
  input wire logic        RST_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [19:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  // Decode and status outputs
  input wire logic        SEL_SRAM,
  input wire logic        SEL_PERIPH,
  input wire logic        SEL_BOOT_ROM,
  input wire logic        SEL_FLASH,
  input wire logic        SEL_SYSCTL,
  input wire logic        SEL_PMU,
  input wire logic        SEL_DISPLAY,
  input wire logic [19:0] FETCH_START_ADDR,
  input wire logic        CORE_SUPPLY_LOW,
  input wire logic        CPU_CLK_HOLD,
  input wire logic        LOW_POWER_IDLE_SEL,
  input wire logic [7:0]  PORT1_PIN_IRQ_ENABLE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  wire logic rd_acc = PSEL && PENABLE && !PWRITE;
  wire logic wr_acc = PSEL && PENABLE && PWRITE;
  ////////////////////////////////////////////////////////////
  a_ready_high: assert property (PREADY) else $error("wait state seen");
  a_hold_follows: assert property (CPU_CLK_HOLD == CORE_SUPPLY_LOW) else $error("clock hold wrong");
  a_fetch_vector: assert property (FETCH_START_ADDR == 20'h80000) else $error("fetch start wrong");
  a_sram_decode: assert property (SEL_SRAM == (PADDR <= 20'h01fff)) else $error("sram decode");
  a_periph_decode: assert property (SEL_PERIPH == (PADDR >= 20'h40000 && PADDR <= 20'h4ffff))
    else $error("periph decode");
  a_sysctl_decode: assert property (SEL_SYSCTL == (PADDR[19:8] == 12'h401)) else $error("block decode");
  a_boot_decode: assert property (SEL_BOOT_ROM == (PADDR >= 20'h80000 && PADDR <= 20'h81fff))
    else $error("boot decode");
  a_flash_decode: assert property (SEL_FLASH == (PADDR >= 20'h90000 && PADDR <= 20'haffff))
    else $error("flash decode");
  a_pmu_decode: assert property (SEL_PMU == (PADDR[19:8] == 12'h404))
    else $error("pmu block decode");
  a_display_decode: assert property (SEL_DISPLAY == (PADDR[19:8] == 12'h41b))
    else $error("display block decode");
  a_mask_zero: assert property (rd_acc && PADDR == 20'h40010 |-> {PRDATA[31:24], PRDATA[15:8]} == 16'h0000)
    else $error("mask bits read nonzero");
  a_cfg_fixed: assert property (rd_acc && PADDR == 20'h40104 |-> PRDATA[31:16] == 16'h0f1a)
    else $error("config half wrong");
  a_idle_masked: assert property (wr_acc && PADDR == 20'h40104 |=> LOW_POWER_IDLE_SEL ==
    ($past(PWDATA[12]) ? $past(PWDATA[4]) : $past(LOW_POWER_IDLE_SEL))) else $error("idle select write");
  a_enable_masked: assert property (wr_acc && PADDR == 20'h40010 |=> PORT1_PIN_IRQ_ENABLE ==
    (($past(PWDATA[31:24]) & $past(PWDATA[23:16])) | (~$past(PWDATA[31:24]) & $past(PORT1_PIN_IRQ_ENABLE))))
    else $error("enable write");
  c_irq_write: cover property (wr_acc && PADDR == 20'h40010);
  c_status_read: cover property (rd_acc && PADDR == 20'h40104);
  c_supply_low: cover property (CPU_CLK_HOLD);
endmodule
////////////////////////////////////////////////////////////
bind mwsr_top mwsr_props u_props (.*);
`default_nettype wire

// ---- dv/mwsr_cpu_model.sv ----
// Bus master model standing in for the CPU core
`timescale 1ns/1ps
`default_nettype none
module mwsr_cpu_model (
  // Clock and answer
  input  wire logic        clk,
  input  wire logic        pready,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [19:0] paddr,
  output logic      [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 20'h00000;
    pwdata = 32'h00000000;
  end
  // Released address and data lines show inverted values so stale data cannot pass for a hold
  task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    psel = 1'b1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge clk);
    penable = 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 16);
    @(negedge clk);
    psel = 1'b0;
    penable = 1'b0;
    paddr = ~a;
    pwdata = ~d;
  endtask
endmodule
`default_nettype wire

// ---- dv/mwsr_top_bench.sv ----
// Self-checking bench for the masked-write status register bank
`timescale 1ns/1ps
`default_nettype none
module mwsr_top_bench;
  import mwsr_pkg::*;
  localparam logic [32:0] ALL = '1;
  logic clk = 1'b0, rst_n = 1'b0, v_hi = 1'b0, v_lo = 1'b0, v_ok = 1'b1, idle = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, idle_o, hold_o;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [31:0] lfsr = 32'hc25f2741;
  logic [3:0]  strb = 4'hf;
  logic [7:0]  ev = 8'h00, pin_evt = 8'h00, en = 8'h00, fl = 8'h00, st = 8'h00, en_o, fl_o;
  logic [32:0] exp_q[$], care_q[$];
  logic [19:0] eaddr[6] = '{20'h01fff, 20'h02000, 20'h81fff, 20'h82000, 20'haffff, 20'hb0000};
  int          num_errors = 0, cmp_count = 0;
  always #2 clk = ~clk;
  mwsr_cpu_model i_cpu (.clk(clk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  mwsr_top i_dut (.REF_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(strb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SEL_SRAM(), .SEL_PERIPH(), .SEL_BOOT_ROM(), .SEL_FLASH(), .SEL_SYSCTL(), .SEL_PMU(), .SEL_DISPLAY(),
    .FETCH_START_ADDR(), .CORE_SUPPLY_HIGH(v_hi), .CORE_SUPPLY_LOW(v_lo), .CORE_RESET_EVT(ev[0]),
    .LOW_POWER_EVT(ev[1]), .TIMER_EXPIRY_EVT(ev[2]), .PIN_RESET_EVT(ev[3]), .CIRCUIT_RESET_EVT(ev[4]),
    .EXT_RESET_EVT(ev[5]), .BROWNOUT_EVT(ev[6]), .PROG_RESET_EVT(ev[7]), .SUPPLY_ABOVE_1V8(v_ok),
    .PORT1_PIN_EVT(pin_evt), .LOW_POWER_IDLE_SEL(idle_o), .CPU_CLK_HOLD(hold_o),
    .PORT1_PIN_IRQ_ENABLE(en_o), .PORT1_PIN_IRQ_FLAG(fl_o));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [32:0] stx();
    return {17'h00f1a, 8'h00, v_hi, v_lo, st[5], idle, st[3:0]};
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] want, input string what);
    cmp_count++;
    if (seen !== want) begin
      num_errors++;
      $display("FAIL t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic rd(input logic [19:0] a, input logic [32:0] want, input logic [32:0] care);
    exp_q.push_back(want & care);
    care_q.push_back(care);
    i_cpu.xfer(1'b0, a, 32'h00000000);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Read data is taken at the access edge, before that edge's updates land
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) check(33'h0, ALL, "unexpected read");
      else check({pslverr, prdata} & care_q.pop_front(), exp_q.pop_front(), "read data");
    end
  end
  initial begin
    #20000;
    num_errors++;
    conclude();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    rd(20'h40010, 33'h0, ALL);
    rd(20'h40104, stx(), ALL);
    $display("reset test done");
    for (int i = 0; i < 14; i++) begin
      lfsr = nxt(lfsr);
      d = (i == 0) ? 32'hffffffff : (i == 1) ? 32'h00ff00ff : lfsr;
      i_cpu.xfer(1'b1, 20'h40010, d);
      en = (en & ~d[31:24]) | (d[23:16] & d[31:24]);
      fl = (fl & ~d[15:8]) | (d[7:0] & d[15:8]);
      check({17'h0, en_o, fl_o}, {17'h0, en, fl}, "masked write");
      rd(20'h40010, {9'h0, en, 8'h00, fl}, ALL);
    end
    @(negedge clk) pin_evt = 8'h02;
    i_cpu.xfer(1'b1, 20'h40010, 32'h0000ff00);
    pin_evt = 8'h00;
    rd(20'h40010, {9'h0, en, 16'h0002}, ALL);
    $display("masked write test done");
    foreach (eaddr[i]) rd(eaddr[i], {i[0], 32'h0}, {1'b1, 32'h0});
    rd(20'h40200, 33'h0, ALL);
    rd(20'h40404, 33'h0, ALL);
    rd(20'h41b00, 33'h0, ALL);
    i_cpu.xfer(1'b1, 20'h00100, lfsr);
    rd(20'h00100, {1'b0, lfsr}, ALL);
    // Single byte lane write must leave the other three lanes alone
    strb = 4'h2;
    i_cpu.xfer(1'b1, 20'h00100, 32'h00000000);
    strb = 4'hf;
    rd(20'h00100, {1'b0, lfsr[31:16], 8'h00, lfsr[7:0]}, ALL);
    $display("decode test done");
    foreach (eaddr[i]) begin
      d = (i == 0) ? 32'h00001010 : (i == 1) ? 32'h00000000 : (i == 2) ? 32'hffffefef : 32'h00001000;
      i_cpu.xfer(1'b1, 20'h40104, d);
      if (d[12]) idle = d[4];
      check({32'h0, idle_o}, {32'h0, idle}, "idle select");
      rd(20'h40104, stx(), ALL);
    end
    for (int i = 0; i < 8; i++) begin
      @(negedge clk) ev = 8'h01 << i;
      @(negedge clk) ev = 8'h00;
      case (i)
        0: st[5] = 1'b1;
        1: st[3] = 1'b1;
        2: st[2] = 1'b1;
        3: st[1] = 1'b1;
        4: st[3] = 1'b0;
        5: st[2] = 1'b0;
        6: st[1:0] = 2'b01;
        default: st[1] = 1'b1;
      endcase
      rd(20'h40104, stx(), ALL);
    end
    @(negedge clk) v_ok = 1'b0;
    @(negedge clk) v_ok = 1'b1;
    v_hi = 1'b1;
    v_lo = 1'b1;
    st[0] = 1'b0;
    @(negedge clk);
    check({32'h0, hold_o}, 33'h1, "clock hold");
    rd(20'h40104, stx(), ALL);
    $display("status test done");
    check(33'(exp_q.size()), 33'h0, "reads missing");
    conclude();
  end
endmodule
`default_nettype wire
